// >>> design/adp_data_path.sv
// adp_data_path: config register, input xor gate, output select, byte input registers
// assumes single-cycle sfr reads and writes, cpu or dma on the same bus; core is external
//
// Behaviour
// - output select routes direct result, result xor xor-byte, or inverse key; 11 reserved
// - xor enable set: block byte xor xor-byte goes to core data input
// - xor enable clear: block byte goes unchanged to core data input
// - block input and xor input accept direct dma byte writes
// - reading block or xor input returns last written byte, no side effect
// - registers decode at 0xEA to 0xED on page 0x2
module adp_data_path #(
  parameter int DataWidth = 8
)
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // sfr bus
  input  wire logic [7:0]           sfrPage,
  input  wire logic [7:0]           sfrAddr,
  input  wire logic                 sfrWrite,
  input  wire logic                 sfrRead,
  input  wire logic [DataWidth-1:0] sfrWdata,
  output logic      [DataWidth-1:0] sfrRdata,
  output logic                      sfrRvalid,
  // cipher core side
  input  wire logic [DataWidth-1:0] coreResult,
  input  wire logic [DataWidth-1:0] inverseKey,
  output logic      [DataWidth-1:0] coreDataIn,
  output logic                      coreDataStrobe,
  output logic      [DataWidth-1:0] keyByte,
  output logic                      keyStrobe,
  output logic      [DataWidth-1:0] cipherOutput
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // the register map is byte wide; other widths cannot be served
  if (DataWidth != 8)
  begin : g_bad_width
    $error("adp_data_path: DataWidth must be 8");
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic onPage;
  logic hitCfg;
  logic hitBlk;
  logic hitXor;
  logic hitKey;

  // page and address compare, full byte decode
  always_comb
  begin
    onPage = (sfrPage == adp_pkg::SFR_PAGE_AES);
    hitCfg = onPage && (sfrAddr == adp_pkg::ADDR_DATA_CFG);
    hitBlk = onPage && (sfrAddr == adp_pkg::ADDR_BLOCK_IN);
    hitXor = onPage && (sfrAddr == adp_pkg::ADDR_XOR_IN);
    hitKey = onPage && (sfrAddr == adp_pkg::ADDR_KEY_IN);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] blk_reg, blk_next;
  logic [7:0] xin_reg, xin_next;
  logic [7:0] kin_reg, kin_next;
  logic       blkStb_reg, blkStb_next;
  logic       keyStb_reg, keyStb_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  logic [7:0] din_reg, din_next;
  logic [7:0] yout_reg, yout_next;
  logic [7:0] feed;
  logic       xorEn;
  adp_pkg::adp_sel_t output_source_select;

  always_comb
  begin
    xorEn  = cfg_reg[adp_pkg::CFG_XOR_EN_BIT];
    output_source_select = adp_pkg::adp_sel_t'(cfg_reg[adp_pkg::CFG_SEL_MSB:adp_pkg::CFG_SEL_LSB]);
  end

  // write path; cpu and dma share the port, so dma writes land identically
  always_comb
  begin
    cfg_next    = cfg_reg;
    blk_next    = blk_reg;
    xin_next    = xin_reg;
    kin_next    = kin_reg;
    blkStb_next = 1'b0;
    keyStb_next = 1'b0;
    if (sfrWrite && hitCfg)
    begin
      cfg_next = sfrWdata & adp_pkg::CFG_WRITE_MASK;
    end
    else if (sfrWrite && hitBlk)
    begin
      blk_next    = sfrWdata;
      blkStb_next = 1'b1;
    end
    else if (sfrWrite && hitXor)
    begin
      xin_next = sfrWdata;
    end
    else if (sfrWrite && hitKey)
    begin
      kin_next    = sfrWdata;
      keyStb_next = 1'b1;
    end
  end

  // input xor gate; uses the xor byte written before the block byte
  always_comb
  begin
    feed     = xorEn ? (sfrWdata ^ xin_reg) : sfrWdata;
    din_next = (sfrWrite && hitBlk) ? feed : din_reg;
  end

  // output source select; reserved code reads zero
  always_comb
  begin
    case (output_source_select)
      adp_pkg::SEL_DIRECT:  yout_next = coreResult;
      adp_pkg::SEL_XOR:     yout_next = coreResult ^ xin_reg;
      adp_pkg::SEL_INV_KEY: yout_next = inverseKey;
      default:              yout_next = adp_pkg::RESET_BYTE;
    endcase
  end

  // read mux; reads change no state
  always_comb
  begin
    rvalid_next = sfrRead && (hitCfg || hitBlk || hitXor || hitKey);
    if (hitCfg)
    begin
      rdata_next = cfg_reg;
    end
    else if (hitBlk)
    begin
      rdata_next = blk_reg;
    end
    else if (hitXor)
    begin
      rdata_next = xin_reg;
    end
    else if (hitKey)
    begin
      rdata_next = kin_reg;
    end
    else
    begin
      rdata_next = adp_pkg::RESET_BYTE;
    end
    if (!sfrRead)
    begin
      rdata_next = adp_pkg::RESET_BYTE;
    end
  end

  // state registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_reg    <= adp_pkg::RESET_BYTE;
      blk_reg    <= adp_pkg::RESET_BYTE;
      xin_reg    <= adp_pkg::RESET_BYTE;
      kin_reg    <= adp_pkg::RESET_BYTE;
      blkStb_reg <= 1'b0;
      keyStb_reg <= 1'b0;
      rdata_reg  <= adp_pkg::RESET_BYTE;
      rvalid_reg <= 1'b0;
      din_reg    <= adp_pkg::RESET_BYTE;
      yout_reg   <= adp_pkg::RESET_BYTE;
    end
    else
    begin
      cfg_reg    <= cfg_next;
      blk_reg    <= blk_next;
      xin_reg    <= xin_next;
      kin_reg    <= kin_next;
      blkStb_reg <= blkStb_next;
      keyStb_reg <= keyStb_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      din_reg    <= din_next;
      yout_reg   <= yout_next;
    end
  end

  // outputs straight from flops
  assign sfrRdata       = rdata_reg;
  assign sfrRvalid      = rvalid_reg;
  assign coreDataIn     = din_reg;
  assign coreDataStrobe = blkStb_reg;
  assign keyByte        = kin_reg;
  assign keyStrobe      = keyStb_reg;
  assign cipherOutput   = yout_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_xor_in;
    @(posedge ref_clk) disable iff (!reset_n)
      (sfrWrite && hitBlk && xorEn) |=> (coreDataIn == ($past(sfrWdata) ^ $past(xin_reg)));
  endproperty
  a_xor_in: assert property (p_xor_in) else $error("input xor wrong");

  property p_bypass;
    @(posedge ref_clk) disable iff (!reset_n)
      (sfrWrite && hitBlk && !xorEn) |=> (coreDataIn == $past(sfrWdata) && coreDataStrobe);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");

  property p_out_xor;
    @(posedge ref_clk) disable iff (!reset_n)
      (output_source_select == adp_pkg::SEL_XOR) |=> (cipherOutput == ($past(coreResult) ^ $past(xin_reg)));
  endproperty
  a_out_xor: assert property (p_out_xor) else $error("output xor wrong");

  property p_out_key;
    @(posedge ref_clk) disable iff (!reset_n)
      (output_source_select == adp_pkg::SEL_INV_KEY) |=> (cipherOutput == $past(inverseKey));
  endproperty
  a_out_key: assert property (p_out_key) else $error("inverse key select wrong");

  property p_readback;
    @(posedge ref_clk) disable iff (!reset_n)
      (sfrWrite && hitXor) ##1 (!sfrWrite) ##1 (sfrRead && hitXor && !sfrWrite)
        |=> (sfrRdata == $past(sfrWdata, 3));
  endproperty
  a_readback: assert property (p_readback) else $error("xor readback wrong");

  property p_read_quiet;
    @(posedge ref_clk) disable iff (!reset_n)
      (sfrRead && !sfrWrite) |=> $stable(blk_reg) && $stable(xin_reg) && !coreDataStrobe;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed state");

  property p_decode;
    @(posedge ref_clk) disable iff (!reset_n)
      (sfrRead && !onPage) |=> (!sfrRvalid && sfrRdata == 8'h00);
  endproperty
  a_decode: assert property (p_decode) else $error("off-page access answered");

  property p_cfg_zero;
    @(posedge ref_clk) disable iff (!reset_n)
      (sfrRead && hitCfg) |=> (sfrRdata[7:3] == 5'h00);
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("config high bits nonzero");

  c_xor_in:  cover property (@(posedge ref_clk) sfrWrite && hitBlk && xorEn);
  c_key:     cover property (@(posedge ref_clk) output_source_select == adp_pkg::SEL_INV_KEY);
  c_group:   cover property (@(posedge ref_clk)
    (sfrWrite && hitBlk) ##1 (sfrWrite && hitXor) ##1 (sfrWrite && hitKey));

endmodule

// >>> design/adp_pkg.sv
// adp_pkg: constants for the data-path front end of the byte-wide cipher block
// assumes an sfr bus with page select, 8-bit address and byte data
package adp_pkg;

  // ----------------------------------------
  // sfr decode
  // ----------------------------------------
  localparam logic [7:0] SFR_PAGE_AES    = 8'h02;
  localparam logic [7:0] ADDR_DATA_CFG   = 8'hEA;
  localparam logic [7:0] ADDR_BLOCK_IN   = 8'hEB;
  localparam logic [7:0] ADDR_XOR_IN     = 8'hEC;
  localparam logic [7:0] ADDR_KEY_IN     = 8'hED;

  // ----------------------------------------
  // data_path_config fields and reset values
  // ----------------------------------------
  localparam int         CFG_XOR_EN_BIT  = 0;
  localparam int         CFG_SEL_LSB     = 1;
  localparam int         CFG_SEL_MSB     = 2;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK  = 8'h07;

  // output source select codes
  typedef enum logic [1:0]
  {
    SEL_DIRECT  = 2'h0,
    SEL_XOR     = 2'h1,
    SEL_INV_KEY = 2'h2,
    SEL_RSVD    = 2'h3
  } adp_sel_t;

endpackage

// >>> sim/adp_host_model.sv
// adp_host_model: byte-wide sfr bus master acting for the cpu or a dma channel
// assumes the bench calls its tasks; bus changes only on the falling edge
module adp_host_model
(
  // clock
  input  wire logic       ref_clk,
  // sfr bus
  output logic      [7:0] sfrPage,
  output logic      [7:0] sfrAddr,
  output logic            sfrWrite,
  output logic            sfrRead,
  output logic      [7:0] sfrWdata,
  input  wire logic [7:0] sfrRdata,
  input  wire logic       sfrRvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus; data flips after each write so a stale byte never looks valid
  initial
  begin
    sfrPage  = 8'h00;
    sfrAddr  = 8'h00;
    sfrWrite = 1'b0;
    sfrRead  = 1'b0;
    sfrWdata = 8'h00;
  end

  // one byte per strobe, cpu and dma alike; plaintext, ciphertext or key
  // bytes all go through the same write
  task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    sfrPage  = page;
    sfrAddr  = addr;
    sfrWdata = data;
    sfrWrite = 1'b1;
    @(negedge ref_clk);
    sfrWrite = 1'b0;
    sfrWdata = ~data;
  endtask

  // answer stands right after the taking edge, sampled half a cycle later before release
  task automatic rd(input logic [7:0] page, input logic [7:0] addr,
                    output logic [7:0] data, output logic valid);
    @(negedge ref_clk);
    sfrPage = page;
    sfrAddr = addr;
    sfrRead = 1'b1;
    @(negedge ref_clk);
    data    = sfrRdata;
    valid   = sfrRvalid;
    sfrRead = 1'b0;
  endtask
endmodule

// >>> sim/testbench.sv
// testbench: directed register-bus tests of the data-path front end
// assumes adp_pkg and adp_host_model are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk;
  logic       reset_n;
  logic [7:0] sfrPage;
  logic [7:0] sfrAddr;
  logic [7:0] sfrWdata;
  logic [7:0] sfrRdata;
  logic [7:0] coreResult;
  logic [7:0] inverseKey;
  logic [7:0] coreDataIn;
  logic [7:0] keyByte;
  logic [7:0] cipherOutput;
  logic [7:0] x;
  logic [7:0] e;
  logic       sfrWrite;
  logic       sfrRead;
  logic       sfrRvalid;
  logic       coreDataStrobe;
  logic       keyStrobe;
  int         errTotal;
  int         compares;
  localparam logic [7:0] PG = adp_pkg::SFR_PAGE_AES;

  adp_host_model u_host (
    .ref_clk   (ref_clk),
    .sfrPage   (sfrPage),
    .sfrAddr   (sfrAddr),
    .sfrWrite  (sfrWrite),
    .sfrRead   (sfrRead),
    .sfrWdata  (sfrWdata),
    .sfrRdata  (sfrRdata),
    .sfrRvalid (sfrRvalid)
  );
  adp_data_path u_dut (
    .ref_clk        (ref_clk),
    .reset_n        (reset_n),
    .sfrPage        (sfrPage),
    .sfrAddr        (sfrAddr),
    .sfrWrite       (sfrWrite),
    .sfrRead        (sfrRead),
    .sfrWdata       (sfrWdata),
    .sfrRdata       (sfrRdata),
    .sfrRvalid      (sfrRvalid),
    .coreResult     (coreResult),
    .inverseKey     (inverseKey),
    .coreDataIn     (coreDataIn),
    .coreDataStrobe (coreDataStrobe),
    .keyByte        (keyByte),
    .keyStrobe      (keyStrobe),
    .cipherOutput   (cipherOutput)
  );

  // -----------------------------------
  // checking
  // -----------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdchk(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp,
                       input logic ev);
    logic [7:0] d;
    logic       v;
    u_host.rd(pg, a, d, v);
    chk("rvalid", {7'h00, v}, {7'h00, ev});
    chk("rdata", d, exp);
  endtask

  task automatic results;
    if (errTotal == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // -----------------------------------
  // stimulus
  // -----------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    errTotal   = 0;
    compares   = 0;
    reset_n    = 1'b0;
    coreResult = 8'h00;
    inverseKey = 8'h00;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int a = 0; a < 4; a++)
      rdchk(PG, 8'(adp_pkg::ADDR_DATA_CFG + a), 8'h00, 1'b1);
    u_host.wr(PG, adp_pkg::ADDR_DATA_CFG, 8'hFF);
    rdchk(PG, adp_pkg::ADDR_DATA_CFG, 8'h07, 1'b1);
    // every select code, with a fresh xor byte before each output byte
    for (int s = 0; s < 4; s++)
    begin
      coreResult = 8'(8'h3C + s);
      inverseKey = 8'(8'hA5 - s);
      x = 8'(8'h5A ^ s);
      u_host.wr(PG, adp_pkg::ADDR_XOR_IN, x);
      u_host.wr(PG, adp_pkg::ADDR_DATA_CFG, 8'(s << 1));
      @(negedge ref_clk);
      e = (s == 0) ? coreResult : (s == 1) ? coreResult ^ x : (s == 2) ? inverseKey : 8'h00;
      chk("cipherOutput", cipherOutput, e);
    end
    u_host.wr(PG, adp_pkg::ADDR_BLOCK_IN, 8'hC3);
    chk("coreDataIn", coreDataIn, 8'hC3);
    // interleaved load, xor gate on; gate sees the previous xor byte
    u_host.wr(PG, adp_pkg::ADDR_DATA_CFG, 8'h01);
    for (int i = 0; i < 24; i++)
    begin
      if (i < 16)
      begin
        u_host.wr(PG, adp_pkg::ADDR_BLOCK_IN, 8'(i * 7 + 1));
        chk("coreDataIn", coreDataIn, 8'(i * 7 + 1) ^ x);
        chk("coreDataStrobe", {7'h00, coreDataStrobe}, 8'h01);
        x = 8'(i * 13 + 2);
        u_host.wr(PG, adp_pkg::ADDR_XOR_IN, x);
        chk("coreDataStrobe", {7'h00, coreDataStrobe}, 8'h00);
      end
      u_host.wr(PG, adp_pkg::ADDR_KEY_IN, 8'(255 - i));
      chk("keyByte", keyByte, 8'(255 - i));
      chk("keyStrobe", {7'h00, keyStrobe}, 8'h01);
    end
    rdchk(PG, adp_pkg::ADDR_BLOCK_IN, 8'(15 * 7 + 1), 1'b1);
    // fresh xor byte read back right after the write, one idle cycle between
    x = 8'h6D;
    u_host.wr(PG, adp_pkg::ADDR_XOR_IN, x);
    rdchk(PG, adp_pkg::ADDR_XOR_IN, x, 1'b1);
    chk("coreDataStrobe", {7'h00, coreDataStrobe}, 8'h00);
    // wrong page and unmapped address are ignored
    u_host.wr(8'h01, adp_pkg::ADDR_BLOCK_IN, 8'h99);
    rdchk(PG, adp_pkg::ADDR_BLOCK_IN, 8'(15 * 7 + 1), 1'b1);
    rdchk(8'h01, adp_pkg::ADDR_XOR_IN, 8'h00, 1'b0);
    rdchk(PG, 8'hE9, 8'h00, 1'b0);
    // reset in mid-run clears everything
    reset_n = 1'b0;
    @(negedge ref_clk);
    chk("keyByte", keyByte, 8'h00);
    reset_n = 1'b1;
    rdchk(PG, adp_pkg::ADDR_XOR_IN, 8'h00, 1'b1);
    results();
  end
endmodule
